// *** adc_cal_pkg.sv ***
package adc_cal_pkg;

   // modulator bit period and trigger width, in master clock cycles
   localparam int BIT_CYCLES      = 256;
   localparam int TRIG_MIN_CYCLES = 4;

   // calibration durations in master clock periods
   localparam int SELF_CAL_CYCLES   = 3145655;
   localparam int SYS_OFF_CYCLES    = 1052599;
   localparam int SYS_GAIN_CYCLES   = 1068813;
   localparam int ONE_STEP_CYCLES   = 2117389;
   // modulator bits per ones-density window (1024 x 256 cycles)
   localparam int WIN_BITS_DEFAULT  = 1024;

   // datapath widths
   localparam int DW     = 20;
   localparam int CODE_W = 20;
   localparam int NUM_W  = 40;
   localparam int TOT_W  = 22;
   localparam int ADDR_W = 8;

   // resolution and code constants
   localparam logic [4:0]        RES16_SHIFT = 5'h10;
   localparam logic [4:0]        RES20_SHIFT = 5'h14;
   localparam logic [CODE_W-1:0] MAX16       = 20'h0ffff;
   localparam logic [CODE_W-1:0] MAX20       = 20'hfffff;
   localparam logic [CODE_W-1:0] HALF16      = 20'h08000;
   localparam logic [CODE_W-1:0] HALF20      = 20'h80000;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ZERO   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_SPAN   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_LSB    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h14;

   // field positions
   localparam int CTRL_RES20_BIT   = 0;
   localparam int STAT_BUSY_BIT    = 0;
   localparam int STAT_VALID_BIT   = 1;
   localparam int STAT_READY_N_BIT = 2;
   localparam int STAT_BIPOLAR_BIT = 3;
   localparam int STAT_MODE_LSB    = 4;
   localparam logic CTRL_RESET     = 1'b0;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {
      MODE_SELF, MODE_SYS_OFFSET, MODE_SYS_GAIN, MODE_ONE_STEP
   } cal_mode_t;

   typedef enum logic [1:0] {SRC_GROUND, SRC_REF, SRC_INPUT} src_t;

   // select pins a,b to calibration type
   function automatic cal_mode_t decode_mode(input logic a, input logic b);
      unique case ({a, b})
         2'b00:   return MODE_SELF;
         2'b11:   return MODE_SYS_OFFSET;
         2'b01:   return MODE_SYS_GAIN;
         default: return MODE_ONE_STEP;
      endcase
   endfunction

   // number of segments as a power of two: resolution, one less in bipolar
   function automatic logic [4:0] code_shift(input logic res20, input logic bip);
      return (res20 ? RES20_SHIFT : RES16_SHIFT) - {4'h0, bip};
   endfunction

endpackage

// *** density_window.sv ***
`timescale 1ns/1ps
`default_nettype none

module density_window import adc_cal_pkg::*; #(
   parameter int WIN_BITS = WIN_BITS_DEFAULT
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          srst,
   // control
   input  wire logic          clear,
   input  wire logic          tick,
   input  wire logic          bit_val,
   // result
   output logic [DW-1:0]      ones,
   output logic               done
);
   import adc_cal_pkg::*;

   typedef struct packed {
      logic [DW-1:0] ones;
      logic [DW-1:0] ticks;
      logic          done;
   } win_t;

   win_t st, nxt;

   // count ones over a fixed number of bit periods, then hold
   always_comb begin
      nxt = st;
      if (clear) begin
         nxt = '0;
      end else if (tick && !st.done) begin
         nxt.ones  = st.ones + DW'(bit_val);
         nxt.ticks = st.ticks + 20'h00001;
         nxt.done  = (st.ticks == DW'(WIN_BITS - 1));
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) st <= '0;
      else      st <= nxt;
   end

   assign ones = st.ones;
   assign done = st.done;

endmodule // density_window

`default_nettype wire

// *** adc_cal_sequencer.sv ***
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - modulator bit changes only once per 256 master clock cycles
// - measure ones density at zero scale, then full scale, derive slope
// - unipolar self-cal uses ground as zero, reference as full scale
// - unipolar slope divides span into 2^resolution segments
// - bipolar divides span into half as many, extended below zero
// - keep slope after calibration and use it for every conversion
// - selects 00 self, 11 offset step, 01 gain step, 10 one-step
// - self-calibration lasts 3,145,655 clock periods
// - system offset step lasts 1,052,599 clock periods
// - system gain step lasts 1,068,813 clock periods
// - one-step system calibration lasts 2,117,389 clock periods
// - ready output stays high through the whole calibration
// - self-cal ends after input settling; others end when term is known
// - later offset-only step moves zero point, leaves slope alone
// - one-step mode takes zero from input, full scale from reference
module adc_cal_sequencer import adc_cal_pkg::*; #(
   parameter int T_SELF   = SELF_CAL_CYCLES,
   parameter int T_OFF    = SYS_OFF_CYCLES,
   parameter int T_GAIN   = SYS_GAIN_CYCLES,
   parameter int T_ONE    = ONE_STEP_CYCLES,
   parameter int WIN_BITS = WIN_BITS_DEFAULT
) (
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                srst,
   // calibration pins
   input  wire logic                trim_request,
   input  wire logic                mode_select_a,
   input  wire logic                mode_select_b,
   input  wire logic                polarity_select,
   output logic                     result_ready_n,
   // modulator side
   input  wire logic                mod_comparator,
   output logic                     modulator_stream,
   output adc_cal_pkg::src_t        input_sel,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0]   araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready
);
   import adc_cal_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_TRIG, ST_ZERO, ST_FULL, ST_SETTLE, ST_MEAS, ST_DIV
   } state_t;

   typedef struct packed {
      state_t              state;
      cal_mode_t           mode;
      src_t                src;
      logic [2:0]          trig_cnt;
      logic                trig_d;
      logic [TOT_W-1:0]    tot;
      logic [7:0]          bit_cnt;
      logic                stream;
      logic                ready_n;
      logic                cal_valid;
      logic                res20;
      logic [DW-1:0]       zero;
      logic [DW-1:0]       span;
      logic [DW-1:0]       lsb;
      logic [CODE_W-1:0]   result;
      logic [NUM_W-1:0]    num;
      logic [DW:0]         rem;
      logic [5:0]          div_cnt;
      logic                neg;
      logic [ADDR_W-1:0]   aw_addr;
      logic                aw_got;
      logic [31:0]         w_data;
      logic [3:0]          w_strb;
      logic                w_got;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
   } seq_t;

   seq_t st, nxt;

   logic              tick;
   logic              busy;
   logic              start_w;
   logic              finish_w;
   logic [TOT_W-1:0]  limit_w;
   logic              clr_w;
   logic              win_done;
   logic [DW-1:0]     dens_ones;

   // final code from quotient, clamped to the code range
   function automatic logic [CODE_W-1:0] final_code(input logic [NUM_W-1:0] q,
         input logic neg, input logic res20, input logic bip);
      logic [CODE_W-1:0] maxc;
      logic [CODE_W-1:0] half;
      maxc = res20 ? MAX20 : MAX16;
      half = res20 ? HALF20 : HALF16;
      if (!bip) begin
         if (neg) return '0;
         return (q > NUM_W'(maxc)) ? maxc : q[CODE_W-1:0];
      end
      if (neg) return (q >= NUM_W'(half)) ? '0 : half - q[CODE_W-1:0];
      return (q > NUM_W'(maxc - half)) ? maxc : half + q[CODE_W-1:0];
   endfunction

   // one bit period ends when the phase counter wraps
   assign tick     = (st.bit_cnt == 8'hff);
   assign busy     = (st.state == ST_ZERO) || (st.state == ST_FULL) ||
                     (st.state == ST_SETTLE);
   assign start_w  = (st.state == ST_TRIG) && !trim_request &&
                     (st.trig_cnt >= 3'(TRIG_MIN_CYCLES));
   assign limit_w  = (st.mode == MODE_SELF)       ? TOT_W'(T_SELF - 1) :
                     (st.mode == MODE_SYS_OFFSET) ? TOT_W'(T_OFF - 1)  :
                     (st.mode == MODE_SYS_GAIN)   ? TOT_W'(T_GAIN - 1) :
                                                    TOT_W'(T_ONE - 1);
   assign finish_w = busy && (st.tot == limit_w);

   density_window #(.WIN_BITS(WIN_BITS)) u_window (
      .core_clk (core_clk),
      .srst     (srst),
      .clear    (clr_w),
      .tick     (tick),
      .bit_val  (nxt.stream),  // the bit being sampled; the held one belongs to the old source
      .ones     (dens_ones),
      .done     (win_done)
   );

   // sequencer, divider and register slave in one next-state process
   always_comb begin
      logic [DW:0]   diff;
      logic [DW:0]   abs_d;
      logic [DW:0]   rem_sh;
      logic [DW-1:0] span_v;
      nxt    = st;
      clr_w  = 1'b0;
      diff   = {1'b0, dens_ones} - {1'b0, st.zero};
      abs_d  = diff[DW] ? (~diff + 21'h000001) : diff;
      rem_sh = {st.rem[DW-1:0], st.num[NUM_W-1]};
      span_v = (dens_ones > st.zero) ? diff[DW-1:0] : 20'h00001;
      nxt.bit_cnt = st.bit_cnt + 8'h01;
      nxt.trig_d  = trim_request;
      if (tick) nxt.stream = mod_comparator;
      if (busy) nxt.tot = st.tot + 22'h000001;
      unique case (st.state)
         ST_IDLE: ;
         ST_TRIG: begin
            if (!trim_request) nxt.state = ST_IDLE;
         end
         ST_ZERO: begin
            if (win_done) begin
               nxt.zero = dens_ones;
               clr_w    = 1'b1;
               if (st.mode == MODE_SYS_OFFSET) begin
                  nxt.state = ST_SETTLE;
                  nxt.src   = SRC_INPUT;
               end else begin
                  nxt.state = ST_FULL;
                  nxt.src   = SRC_REF;
               end
            end
         end
         ST_FULL: begin
            if (win_done) begin
               nxt.span  = span_v;
               nxt.lsb   = span_v >> code_shift(st.res20, polarity_select);
               nxt.state = ST_SETTLE;
               nxt.src   = SRC_INPUT;
               clr_w     = 1'b1;
            end
         end
         ST_SETTLE: ;
         ST_MEAS: begin
            if (win_done) begin
               clr_w = 1'b1;
               if (st.cal_valid) begin
                  // stored zero and span scale every conversion
                  nxt.num     = NUM_W'(abs_d) << code_shift(st.res20, polarity_select);
                  nxt.neg     = diff[DW];
                  nxt.rem     = '0;
                  nxt.div_cnt = '0;
                  nxt.state   = ST_DIV;
               end
            end
         end
         ST_DIV: begin
            // restoring division, one quotient bit per cycle
            if (rem_sh >= {1'b0, st.span}) begin
               nxt.rem = rem_sh - {1'b0, st.span};
               nxt.num = {st.num[NUM_W-2:0], 1'b1};
            end else begin
               nxt.rem = rem_sh;
               nxt.num = {st.num[NUM_W-2:0], 1'b0};
            end
            nxt.div_cnt = st.div_cnt + 6'h01;
            if (st.div_cnt == 6'(NUM_W - 1)) begin
               nxt.result = final_code(nxt.num, st.neg, st.res20, polarity_select);
               nxt.state  = ST_MEAS;
            end
         end
      endcase
      // calibration term known: report and start converting the input
      if (finish_w) begin
         nxt.state     = ST_MEAS;
         nxt.ready_n   = 1'b0;
         nxt.cal_valid = 1'b1;
         nxt.src       = SRC_INPUT;
         clr_w         = 1'b1;
      end
      // trigger high resets the sequence; selects are taken at its fall
      if (trim_request) begin
         nxt.state    = ST_TRIG;
         nxt.ready_n  = 1'b1;
         nxt.trig_cnt = !st.trig_d ? 3'h1 :
                        (st.trig_cnt == 3'h7) ? 3'h7 : st.trig_cnt + 3'h1;
      end else if (start_w) begin
         nxt.mode    = decode_mode(mode_select_a, mode_select_b);
         nxt.tot     = '0;
         nxt.ready_n = 1'b1;
         clr_w       = 1'b1;
         if (nxt.mode == MODE_SYS_GAIN) begin
            nxt.state = ST_FULL;
            nxt.src   = SRC_INPUT;
         end else begin
            nxt.state = ST_ZERO;
            nxt.src   = (nxt.mode == MODE_SELF) ? SRC_GROUND : SRC_INPUT;
         end
      end
      // axi write: address and data in either order, answer after both
      if (awvalid && st.awready) begin
         nxt.aw_addr = awaddr;
         nxt.aw_got  = 1'b1;
      end
      if (wvalid && st.wready) begin
         nxt.w_data = wdata;
         nxt.w_strb = wstrb;
         nxt.w_got  = 1'b1;
      end
      if (st.bvalid && bready) nxt.bvalid = 1'b0;
      if (st.aw_got && st.w_got && !st.bvalid) begin
         nxt.aw_got = 1'b0;
         nxt.w_got  = 1'b0;
         nxt.bvalid = 1'b1;
         nxt.bresp  = RESP_OKAY;
         if (st.aw_addr[ADDR_W-1:2] == OFS_CTRL[ADDR_W-1:2]) begin
            if (st.w_strb[0]) nxt.res20 = st.w_data[CTRL_RES20_BIT];
         end else if (st.aw_addr[ADDR_W-1:2] > OFS_RESULT[ADDR_W-1:2]) begin
            nxt.bresp = RESP_DECERR;
         end
      end
      nxt.awready = !nxt.aw_got && !nxt.bvalid;
      nxt.wready  = !nxt.w_got && !nxt.bvalid;
      // axi read: one at a time, unmapped words read zero with decerr
      if (st.rvalid && rready) nxt.rvalid = 1'b0;
      if (arvalid && st.arready) begin
         nxt.rvalid = 1'b1;
         nxt.rresp  = RESP_OKAY;
         nxt.rdata  = '0;
         unique case ({araddr[ADDR_W-1:2], 2'b00})
            OFS_CTRL:   nxt.rdata[CTRL_RES20_BIT] = st.res20;
            OFS_STATUS: begin
               nxt.rdata[STAT_BUSY_BIT]      = busy;
               nxt.rdata[STAT_VALID_BIT]     = st.cal_valid;
               nxt.rdata[STAT_READY_N_BIT]   = st.ready_n;
               nxt.rdata[STAT_BIPOLAR_BIT]   = polarity_select;
               nxt.rdata[STAT_MODE_LSB +: 2] = st.mode;
            end
            OFS_ZERO:   nxt.rdata[DW-1:0]     = st.zero;
            OFS_SPAN:   nxt.rdata[DW-1:0]     = st.span;
            OFS_LSB:    nxt.rdata[DW-1:0]     = st.lsb;
            OFS_RESULT: nxt.rdata[CODE_W-1:0] = st.result;
            default:    nxt.rresp             = RESP_DECERR;
         endcase
      end
      nxt.arready = !nxt.rvalid;
   end

   // everything resets to idle with ready high and no calibration held
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st         <= '0;
         st.state   <= ST_IDLE;
         st.src     <= SRC_INPUT;
         st.ready_n <= 1'b1;
         st.res20   <= CTRL_RESET;
         st.span    <= 20'h00001;
         st.awready <= 1'b1;
         st.wready  <= 1'b1;
         st.arready <= 1'b1;
      end else begin
         st <= nxt;
      end
   end

   assign result_ready_n   = st.ready_n;
   assign modulator_stream = st.stream;
   assign input_sel        = st.src;
   assign awready          = st.awready;
   assign wready           = st.wready;
   assign bvalid           = st.bvalid;
   assign bresp            = st.bresp;
   assign arready          = st.arready;
   assign rvalid           = st.rvalid;
   assign rdata            = st.rdata;
   assign rresp            = st.rresp;

   // checks on the sequencer's own behaviour
   sequence s_zero_to_full;
      (st.state == ST_ZERO) ##1 (st.state == ST_FULL);
   endsequence

   property p_stream_hold;
      @(posedge core_clk) disable iff (srst)
      (st.stream != $past(st.stream)) |-> ($past(st.bit_cnt) == 8'hff);
   endproperty
   a_stream_hold: assert property (p_stream_hold) else $error("stream bit changed mid period");

   property p_zero_stored;
      @(posedge core_clk) disable iff (srst)
      s_zero_to_full |-> (st.zero == $past(dens_ones));
   endproperty
   a_zero_stored: assert property (p_zero_stored) else $error("zero density not stored");

   property p_self_src;
      @(posedge core_clk) disable iff (srst)
      (st.mode == MODE_SELF && st.state == ST_ZERO) |-> (input_sel == SRC_GROUND);
   endproperty
   a_self_src: assert property (p_self_src) else $error("self cal zero not ground");

   property p_one_step_src;
      @(posedge core_clk) disable iff (srst)
      (st.mode == MODE_ONE_STEP && st.state == ST_FULL) |-> (input_sel == SRC_REF);
   endproperty
   a_one_step_src: assert property (p_one_step_src) else $error("one-step full not ref");

   property p_mode_latch;
      @(posedge core_clk) disable iff (srst)
      start_w |=> (st.mode == decode_mode($past(mode_select_a), $past(mode_select_b)));
   endproperty
   a_mode_latch: assert property (p_mode_latch) else $error("mode not latched");

   property p_self_time;
      @(posedge core_clk) disable iff (srst)
      ($fell(result_ready_n) && st.mode == MODE_SELF) |-> (st.tot == TOT_W'(T_SELF));
   endproperty
   a_self_time: assert property (p_self_time) else $error("self cal length wrong");

   property p_gain_time;
      @(posedge core_clk) disable iff (srst)
      (busy && st.mode == MODE_SYS_GAIN) |-> (st.tot < TOT_W'(T_GAIN));
   endproperty
   a_gain_time: assert property (p_gain_time) else $error("gain step overran");

   property p_busy_ready;
      @(posedge core_clk) disable iff (srst)
      busy |-> (result_ready_n && !$fell(result_ready_n));
   endproperty
   a_busy_ready: assert property (p_busy_ready) else $error("ready low during cal");

   property p_done_ready;
      @(posedge core_clk) disable iff (srst)
      (finish_w && !trim_request) |=> (!result_ready_n && st.state == ST_MEAS);
   endproperty
   a_done_ready: assert property (p_done_ready) else $error("ready did not fall");

   property p_offset_keeps_slope;
      @(posedge core_clk) disable iff (srst)
      (busy && st.mode == MODE_SYS_OFFSET) |=> $stable(st.lsb) && $stable(st.span);
   endproperty
   a_offset_keeps_slope: assert property (p_offset_keeps_slope) else $error("slope changed");

endmodule // adc_cal_sequencer

`default_nettype wire

// *** cal_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cal_host_model (
   // clock and bench command
   input  wire logic       core_clk,
   input  wire logic       go,
   input  wire logic [1:0] mode,
   // calibration pins toward the converter
   output logic            trim_request = 1'b0,
   output logic            mode_select_a = 1'b0,
   output logic            mode_select_b = 1'b0
);
   int hold = 0;

   // trigger held high four cycles, selects kept steady across the fall
   always @(posedge core_clk) begin
      if (go && hold == 0) begin
         {mode_select_a, mode_select_b} <= mode;
         trim_request <= 1'b1;
         hold <= 1;
      end else if (hold > 0 && hold < 4) begin
         hold <= hold + 1;
      end else if (hold == 4) begin
         trim_request <= 1'b0;
         hold <= 0;
      end
   end
endmodule // cal_host_model

`default_nettype wire

// *** tb_adc_calibration_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_adc_calibration_sequencer;
   import adc_cal_pkg::*;
   // shortened calibration lengths, all above two windows of four bits
   localparam int TS = 4100, TO = 3600, TG = 3700, T1 = 3900;
   logic        core_clk = 0, srst = 1, go = 0, analog_input = 0, rnd_on = 0, busy = 0, pt = 0, bip = 0;
   logic [1:0]  mode = 0, bresp, rresp;
   logic        trim_request, mode_select_a, mode_select_b, result_ready_n;
   logic        mod_comparator = 0, modulator_stream, ms_prev = 0;
   src_t        input_sel;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 0, rdata, rv, seed = 32'h3dce05cc;
   logic [65:0] re;
   int          mismatches = 0, cmp_count = 0, cyc = 0, s_cyc = 0, last_chg = 0;
   int          tq[$];
   logic [65:0] rq[$];

   adc_cal_sequencer #(.T_SELF(TS), .T_OFF(TO), .T_GAIN(TG), .T_ONE(T1), .WIN_BITS(4))
   u_adc_cal_sequencer (.core_clk(core_clk), .srst(srst), .trim_request(trim_request),
      .mode_select_a(mode_select_a), .mode_select_b(mode_select_b),
      .polarity_select(bip), .result_ready_n(result_ready_n),
      .mod_comparator(mod_comparator), .modulator_stream(modulator_stream),
      .input_sel(input_sel), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   cal_host_model u_cal_host_model (.core_clk(core_clk), .go(go), .mode(mode),
      .trim_request(trim_request), .mode_select_a(mode_select_a),
      .mode_select_b(mode_select_b));

   always #50 core_clk = ~core_clk;

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // write: address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa, pw;
      pa = 1;
      pw = 1;
      rq.push_back({32'h0, er, 32'h0});
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (pa || pw) begin
         @(posedge core_clk);
         if (pa && awready) begin awvalid <= 0; pa = 0; end
         if (pw && wready) begin wvalid <= 0; pw = 0; end
      end
      while (!bvalid) @(posedge core_clk);
      bready <= 0;
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
      rq.push_back({m, er, e});
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 0;
      do @(posedge core_clk); while (!rvalid);
      rready <= 0;
   endtask

   // run one calibration step; the zero or full scale level is set before the trigger
   task automatic cal(input logic [1:0] m, input int t, input logic a, input logic [1:0] en);
      @(posedge core_clk);
      analog_input <= a;
      mode <= m;
      go <= 1;
      tq.push_back(t);
      @(posedge core_clk);
      go <= 0;
      for (int i = 0; i < 9000 && tq.size() != 0; i++) @(posedge core_clk);
      axr(OFS_STATUS, 32'h3f, 32'({en, bip, 3'h2}), RESP_OKAY);
      $display("test cal %b done", m);
   endtask

   // modulator stand-in: ground reads zeros, reference ones, input follows the bench
   always @(posedge core_clk) begin
      seed <= xs(seed);
      mod_comparator <= (input_sel == SRC_REF) | ((input_sel == SRC_INPUT) & (rnd_on ? seed[0] : analog_input));
   end

   // result watcher: bus answers, calibration length, bit-stream spacing
   always @(posedge core_clk) begin
      cyc++;
      if ((bvalid && bready) || (rvalid && rready)) begin
         re = rq.pop_front();
         chk("resp", {30'h0, re[33:32]}, {30'h0, bvalid ? bresp : rresp});
         chk("rdata", re[31:0], rdata & re[65:34]);
      end
      if (pt && !trim_request) begin s_cyc = cyc; busy = 1; end
      pt = trim_request;
      if (busy && !result_ready_n) begin
         chk("cal_len", 32'(tq.pop_front()), 32'(cyc - s_cyc - 1));
         busy = 0;
      end
      if (!srst && modulator_stream !== ms_prev) begin
         if (last_chg != 0) chk("bit_gap", 0, 32'((cyc - last_chg) % BIT_CYCLES));
         last_chg = cyc;
      end
      ms_prev = modulator_stream;
   end

   // watchdog sized well past the whole sequence
   initial begin
      repeat (60000) @(posedge core_clk);
      mismatches++;
      end_sim();
   end

   // unipolar first; bipolar only after a fresh calibration
   initial begin
      repeat (10) @(posedge core_clk);
      srst <= 0;
      axr(OFS_STATUS, 32'h6, 32'h4, RESP_OKAY);
      cal(2'b00, TS, 1'b0, MODE_SELF);
      axr(OFS_ZERO, '1, 32'h0, RESP_OKAY);
      axr(OFS_SPAN, '1, 32'h4, RESP_OKAY);
      cal(2'b11, TO, 1'b0, MODE_SYS_OFFSET);
      cal(2'b01, TG, 1'b1, MODE_SYS_GAIN);
      axr(OFS_SPAN, '1, 32'h4, RESP_OKAY);
      repeat (1500) @(posedge core_clk);
      axr(OFS_RESULT, '1, 32'h0ffff, RESP_OKAY);
      cal(2'b11, TO, 1'b1, MODE_SYS_OFFSET);
      axr(OFS_ZERO, '1, 32'h4, RESP_OKAY);
      axr(OFS_SPAN, '1, 32'h4, RESP_OKAY);
      cal(2'b10, T1, 1'b0, MODE_ONE_STEP);
      axr(OFS_ZERO, '1, 32'h0, RESP_OKAY);
      bip <= 1;
      cal(2'b10, T1, 1'b0, MODE_ONE_STEP);
      repeat (1500) @(posedge core_clk);
      axr(OFS_RESULT, '1, 32'h08000, RESP_OKAY);
      rnd_on <= 1;
      rv = seed;
      axw(OFS_CTRL, rv, RESP_OKAY);
      axr(OFS_CTRL, 32'h1, {31'h0, rv[0]}, RESP_OKAY);
      axw(8'h40, rv, RESP_DECERR);
      axr(8'h40, '1, 32'h0, RESP_DECERR);
      repeat (3000) @(posedge core_clk);
      axr(OFS_STATUS, 32'h6, 32'h2, RESP_OKAY);
      $display("test bus done");
      end_sim();
   end
endmodule // tb_adc_calibration_sequencer

`default_nettype wire
